// >>> logic/mni_pkg.sv
// Purpose: shared constants for the note message interface
// Assumes: bytes arrive and leave through an external serializer
// Notes:   timing counts derived from the 200 MHz clock
package mni_pkg;
	localparam int          CLK_HZ          = 200000000;
	localparam int          SETUP_TIME_S    = 5;
	localparam longint      SETUP_CYCLES    = longint'(SETUP_TIME_S) * CLK_HZ;
	localparam logic [7:0]  ST_NOTE_ON      = 8'h90;
	localparam logic [3:0]  HI_NOTE_OFF     = 4'h8;
	localparam logic [3:0]  HI_NOTE_ON      = 4'h9;
	localparam logic [3:0]  HI_CTRL         = 4'hB;
	localparam logic [3:0]  HI_PROG         = 4'hC;
	localparam logic [3:0]  CHAN_ONE        = 4'h0;
	localparam logic [7:0]  SYS_START       = 8'hF0;
	localparam logic [7:0]  SYS_END         = 8'hF7;
	localparam logic [6:0]  KEY_BASE        = 7'h36;
	localparam logic [6:0]  OCTAVE          = 7'h0C;
	localparam logic [6:0]  PROG_MAX        = 7'h3D;
	localparam logic [6:0]  CC_ALL_OFF      = 7'h7B;
	localparam logic [6:0]  CC_OMNI_OFF     = 7'h7C;
	localparam logic [6:0]  CC_OMNI_ON      = 7'h7D;
	localparam logic [6:0]  FN_DOUBLE       = 7'h00;
	localparam logic [6:0]  FN_UNISON       = 7'h01;
	localparam logic [6:0]  FN_SPLIT        = 7'h02;
	localparam logic [6:0]  FN_UPPER        = 7'h03;
	localparam logic [1:0]  LAYER_PLAY      = 2'h0;
	localparam logic [1:0]  LAYER_DOUBLE    = 2'h1;
	localparam logic [1:0]  LAYER_UNISON    = 2'h2;
	localparam logic        OMNI_RESET      = 1'b1;
	localparam int          BUF_DEPTH       = 2;
	localparam int          BUF_W           = 8;
endpackage

// >>> logic/mni_skid_buf.sv
// Purpose: two-entry byte buffer between transmitter and serializer
// Assumes: single clock, synchronous active-high reset
// Notes:   full and empty reflect the true occupancy
`timescale 1ns/100ps
`default_nettype none
module mni_skid_buf
	import mni_pkg::*;
(
	input  wire logic             clk,     // clock
	input  wire logic             rst,     // sync reset
	input  wire logic             s_valid, // write request
	output logic                  s_ready, // space available
	input  wire logic [BUF_W-1:0] s_data,  // write data
	output logic                  m_valid, // word available
	input  wire logic             m_ready, // reader takes word
	output logic      [BUF_W-1:0] m_data   // oldest word
);
	typedef struct packed {
		logic [BUF_DEPTH-1:0][BUF_W-1:0] mem;
		logic [1:0]                      cnt;
	} mni_buf_t;

	mni_buf_t st;
	mni_buf_t next_st;
	logic     wr;
	logic     rd;

	assign s_ready = (st.cnt != 2'(BUF_DEPTH));
	assign m_valid = (st.cnt != 2'h0);
	assign m_data  = st.mem[0];
	assign wr      = s_valid && s_ready;
	assign rd      = m_valid && m_ready;

	always_comb begin
		next_st = st;
		if (rd) begin
			next_st.mem[0] = st.mem[1];
		end
		if (wr) begin
			if (rd) begin
				next_st.mem[st.cnt - 2'h1] = s_data;
			end else begin
				next_st.mem[st.cnt[0]] = s_data;
			end
		end
		next_st.cnt = st.cnt + {1'b0, wr} - {1'b0, rd};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule
`default_nettype wire

// >>> logic/mni_top.sv
// Purpose: note message transmitter and receiver interpreter
// Assumes: byte serializer outside; key scanner gives raw key index
// Notes:   outgoing bytes pass a two-entry buffer
//
// Overview of operation
// RULE1: transmit only note-on on channel one
// RULE2: send one 90H byte after power-on
// RULE3: key event is 90H, key, velocity
// RULE4: octave transpose shifts transmitted key range
// RULE5: five second setup picks keyboard position
// RULE6: receive omni or channel one only
// RULE7: midi in connected mutes local keyboard
// RULE8: decode note on and note off
// RULE9: program change sets lower program 0-61
// RULE10: ignore all non-mode controllers
// RULE11: controller 123 zero releases all notes
// RULE12: controllers 124/125 zero set omni off/on
// RULE13: exclusive framed F0, id, function, param, F7
// RULE14: function 0 double, function 1 unison
// RULE15: function 2 sets split point or off
// RULE16: function 3 sets upper program 0-61
// RULE17: foreign maker exclusive discarded to F7
// RULE18: omni off drops other channels
`timescale 1ns/100ps
`default_nettype none
module mni_top
	import mni_pkg::*;
#(
	parameter longint   SETUP_CNT  = SETUP_CYCLES,
	parameter bit [6:0] MAKER_ID   = 7'h11 // arbitrary value
)(
	input  wire logic       CLK,          // clock
	input  wire logic       RST,          // sync reset
	input  wire logic       KEY_EVT,      // key event pulse
	input  wire logic [6:0] KEY_IDX,      // raw key index from scanner
	input  wire logic [6:0] KEY_VEL,      // velocity, zero is release
	output logic            KEY_READY,    // key event accepted
	input  wire logic       KEY_HELD,     // some key held now
	input  wire logic       MIDI_IN_CONN, // midi in cable present
	output logic            TX_VALID,     // byte to serializer
	input  wire logic       TX_READY,     // serializer takes byte
	output logic      [7:0] TX_DATA,      // byte out
	input  wire logic       RX_VALID,     // byte from deserializer
	input  wire logic [7:0] RX_DATA,      // byte in
	output logic            LOCAL_EN,     // local keys drive voices
	output logic            SETUP_DONE,   // keyboard position fixed
	output logic      [6:0] KEY_OFFSET,   // offset added to key index
	output logic            VOICE_ON,     // start voice pulse
	output logic            VOICE_OFF,    // release voice pulse
	output logic      [6:0] VOICE_KEY,    // voice key number
	output logic      [6:0] VOICE_VEL,    // voice velocity
	output logic            ALL_OFF,      // release all pulse
	output logic            OMNI,         // omni reception
	output logic      [5:0] LOWER_PROG,   // lower part program
	output logic      [5:0] UPPER_PROG,   // upper part program
	output logic      [1:0] LAYER_MODE,   // play, double, unison
	output logic            SPLIT_ON,     // split active
	output logic      [6:0] SPLIT_KEY     // split point note
);
	typedef enum logic [2:0] {
		TX_BOOT  = 3'b000,
		TX_IDLE  = 3'b001,
		TX_STAT  = 3'b010,
		TX_KEY   = 3'b011,
		TX_VEL   = 3'b100
	} mni_tx_t;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_DAT1  = 3'b001,
		RX_DAT2  = 3'b010,
		RX_SID   = 3'b011,
		RX_SFN   = 3'b100,
		RX_SPAR  = 3'b101,
		RX_SEND  = 3'b110,
		RX_SKIP  = 3'b111
	} mni_rx_t;

	typedef struct packed {
		mni_tx_t     tx;
		logic [6:0]  key;
		logic [6:0]  vel;
		logic [32:0] setup_cnt;
		logic        setup_done;
		logic        setup_held;
		logic [6:0]  held_key;
		logic [6:0]  offset;
		mni_rx_t     rx;
		logic [3:0]  rx_hi;
		logic [6:0]  d1;
		logic [6:0]  fn;
		logic [6:0]  par;
		logic        v_on;
		logic        v_off;
		logic [6:0]  v_key;
		logic [6:0]  v_vel;
		logic        all_off;
		logic        omni;
		logic [5:0]  lower;
		logic [5:0]  upper;
		logic [1:0]  layer;
		logic        split_on;
		logic [6:0]  split_key;
	} mni_state_t;

	mni_state_t st;
	mni_state_t next_st;
	logic       b_valid;
	logic       b_ready;
	logic [7:0] b_data;

	function automatic logic is_prog_ok(input logic [6:0] p);
		return p <= PROG_MAX;
	endfunction

	function automatic logic chan_ok(input logic [3:0] ch, input logic om);
		return om || (ch == CHAN_ONE);
	endfunction

	// ------------------------------------------------------------
	// outgoing byte buffer
	// ------------------------------------------------------------
	mni_skid_buf u_buf (
		.clk     (CLK),
		.rst     (RST),
		.s_valid (b_valid),
		.s_ready (b_ready),
		.s_data  (b_data),
		.m_valid (TX_VALID),
		.m_ready (TX_READY),
		.m_data  (TX_DATA)
	);

	// ------------------------------------------------------------
	// transmit byte select
	// ------------------------------------------------------------
	always_comb begin
		b_valid = 1'b0;
		b_data  = 8'h00;
		unique case (st.tx)
			TX_BOOT: begin
				b_valid = 1'b1; // RULE2
				b_data  = ST_NOTE_ON; // RULE2
			end
			TX_STAT: begin
				b_valid = 1'b1;
				b_data  = ST_NOTE_ON; // RULE1
			end
			TX_KEY: begin
				b_valid = 1'b1;
				b_data  = {1'b0, st.key}; // RULE3
			end
			TX_VEL: begin
				b_valid = 1'b1;
				b_data  = {1'b0, st.vel}; // RULE3
			end
			TX_IDLE: begin
				b_valid = 1'b0;
			end
		endcase
	end

	assign KEY_READY = (st.tx == TX_IDLE) && st.setup_done;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st         = st;
		next_st.v_on    = 1'b0;
		next_st.v_off   = 1'b0;
		next_st.all_off = 1'b0;

		// keyboard position setup window
		if (!st.setup_done) begin
			if (!KEY_HELD) begin
				next_st.setup_held = 1'b0; // RULE5
			end
			if (st.setup_cnt == 33'h0) begin
				next_st.held_key   = KEY_IDX;
				next_st.setup_held = KEY_HELD; // RULE5
			end
			if (st.setup_cnt == 33'(SETUP_CNT - 1)) begin
				next_st.setup_done = 1'b1;
				if (st.setup_held && KEY_HELD) begin
					// transposed: held key becomes default base
					next_st.offset = KEY_BASE - st.held_key; // RULE5 RULE4
				end else begin
					next_st.offset = KEY_BASE; // RULE5
				end
			end else begin
				next_st.setup_cnt = st.setup_cnt + 33'h1;
			end
		end

		// transmitter
		unique case (st.tx)
			TX_BOOT: begin
				if (b_ready) begin
					next_st.tx = TX_IDLE;
				end
			end
			TX_IDLE: begin
				if (KEY_EVT && st.setup_done) begin
					next_st.key = KEY_IDX + st.offset; // RULE4
					next_st.vel = KEY_VEL; // RULE3
					next_st.tx  = TX_STAT;
				end
			end
			TX_STAT: begin
				if (b_ready) begin
					next_st.tx = TX_KEY;
				end
			end
			TX_KEY: begin
				if (b_ready) begin
					next_st.tx = TX_VEL;
				end
			end
			TX_VEL: begin
				if (b_ready) begin
					next_st.tx = TX_IDLE;
				end
			end
		endcase

		// receiver
		if (RX_VALID) begin
			if (RX_DATA[7] && RX_DATA != SYS_END) begin
				next_st.rx_hi = RX_DATA[7:4];
				if (RX_DATA == SYS_START) begin
					next_st.rx = RX_SID; // RULE13
				end else if (!chan_ok(RX_DATA[3:0], st.omni)) begin
					next_st.rx = RX_IDLE; // RULE18 RULE6
				end else if (RX_DATA[7:4] == HI_NOTE_ON
						|| RX_DATA[7:4] == HI_NOTE_OFF
						|| RX_DATA[7:4] == HI_CTRL
						|| RX_DATA[7:4] == HI_PROG) begin
					next_st.rx = RX_DAT1; // RULE6
				end else begin
					next_st.rx = RX_IDLE;
				end
			end else begin
				unique case (st.rx)
					RX_IDLE: begin
						next_st.rx = RX_IDLE;
					end
					RX_DAT1: begin
						next_st.d1 = RX_DATA[6:0];
						if (st.rx_hi == HI_PROG) begin
							if (is_prog_ok(RX_DATA[6:0])) begin
								next_st.lower = RX_DATA[5:0]; // RULE9
							end
							next_st.rx = RX_DAT1;
						end else begin
							next_st.rx = RX_DAT2;
						end
					end
					RX_DAT2: begin
						next_st.rx = RX_DAT1;
						if (st.rx_hi == HI_NOTE_ON) begin
							next_st.v_key = st.d1; // RULE8
							next_st.v_vel = RX_DATA[6:0];
							if (RX_DATA[6:0] == 7'h00) begin
								next_st.v_off = 1'b1; // RULE8
							end else begin
								next_st.v_on = 1'b1; // RULE8
							end
						end else if (st.rx_hi == HI_NOTE_OFF) begin
							next_st.v_key = st.d1;
							next_st.v_vel = RX_DATA[6:0];
							next_st.v_off = 1'b1; // RULE8
						end else if (RX_DATA[6:0] == 7'h00) begin
							// other controllers fall through unused
							if (st.d1 == CC_ALL_OFF) begin
								next_st.all_off = 1'b1; // RULE11 RULE10
							end else if (st.d1 == CC_OMNI_OFF) begin
								next_st.omni = 1'b0; // RULE12 RULE10
							end else if (st.d1 == CC_OMNI_ON) begin
								next_st.omni = 1'b1; // RULE12 RULE10
							end
						end
					end
					RX_SID: begin
						if (RX_DATA[6:0] == MAKER_ID) begin
							next_st.rx = RX_SFN; // RULE13
						end else begin
							next_st.rx = RX_SKIP; // RULE17
						end
					end
					RX_SFN: begin
						next_st.fn = RX_DATA[6:0];
						next_st.rx = RX_SPAR; // RULE13
					end
					RX_SPAR: begin
						next_st.par = RX_DATA[6:0];
						next_st.rx  = RX_SEND; // RULE13
					end
					RX_SEND: begin
						next_st.rx = RX_SKIP;
					end
					RX_SKIP: begin
						next_st.rx = RX_SKIP; // RULE17
					end
				endcase
			end
			if (RX_DATA == SYS_END) begin
				if (st.rx == RX_SEND) begin
					if (st.fn == FN_DOUBLE && st.par == 7'h00) begin
						next_st.layer = LAYER_DOUBLE; // RULE14
					end else if (st.fn == FN_UNISON && st.par == 7'h00) begin
						next_st.layer = LAYER_UNISON; // RULE14
					end else if (st.fn == FN_SPLIT) begin
						next_st.split_on  = (st.par != 7'h00); // RULE15
						next_st.split_key = st.par; // RULE15
					end else if (st.fn == FN_UPPER && is_prog_ok(st.par)) begin
						next_st.upper = st.par[5:0]; // RULE16
					end
				end
				next_st.rx = RX_IDLE; // RULE13 RULE17
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			st            <= '0;
			st.tx         <= TX_BOOT;
			st.rx         <= RX_IDLE;
			st.setup_held <= 1'b1;
			st.offset     <= KEY_BASE;
			st.omni       <= OMNI_RESET;
			st.layer      <= LAYER_PLAY;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign LOCAL_EN   = !MIDI_IN_CONN; // RULE7
	assign SETUP_DONE = st.setup_done;
	assign KEY_OFFSET = st.offset;
	assign VOICE_ON   = st.v_on;
	assign VOICE_OFF  = st.v_off;
	assign VOICE_KEY  = st.v_key;
	assign VOICE_VEL  = st.v_vel;
	assign ALL_OFF    = st.all_off;
	assign OMNI       = st.omni;
	assign LOWER_PROG = st.lower;
	assign UPPER_PROG = st.upper;
	assign LAYER_MODE = st.layer;
	assign SPLIT_ON   = st.split_on;
	assign SPLIT_KEY  = st.split_key;
endmodule
`default_nettype wire

// >>> dv/mni_asserts.sv
// Purpose: port checker for mni_top
// Assumes: one clock, sync reset
// Notes:   bound from tb_top
`timescale 1ns/100ps
`default_nettype none
module mni_asserts
	import mni_pkg::*;
(
	input wire logic       CLK,          // clock
	input wire logic       RST,          // reset
	input wire logic       KEY_READY,    // key taken
	input wire logic       SETUP_DONE,   // setup over
	input wire logic       MIDI_IN_CONN, // cable in
	input wire logic       LOCAL_EN,     // local keys
	input wire logic       TX_VALID,     // tx valid
	input wire logic       TX_READY,     // tx ready
	input wire logic [7:0] TX_DATA,      // tx byte
	input wire logic       RX_VALID,     // rx strobe
	input wire logic [7:0] RX_DATA,      // rx byte
	input wire logic       VOICE_ON,     // voice start
	input wire logic       VOICE_OFF,    // voice stop
	input wire logic       ALL_OFF,      // all stop
	input wire logic       OMNI,         // omni
	input wire logic [5:0] LOWER_PROG,   // lower prog
	input wire logic [5:0] UPPER_PROG,   // upper prog
	input wire logic [1:0] LAYER_MODE,   // layering
	input wire logic       SPLIT_ON,     // split
	input wire logic [6:0] SPLIT_KEY     // split key
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	a_local_mute: assert property (LOCAL_EN == !MIDI_IN_CONN)
		else $error("local enable wrong");
	a_boot_note: assert property ($fell(RST) |-> ##[0:2]
		TX_VALID && TX_DATA == ST_NOTE_ON) else $error("no boot byte");
	a_ready_setup: assert property (KEY_READY |-> SETUP_DONE)
		else $error("key taken in setup");
	a_tx_hold: assert property (TX_VALID && !TX_READY |=>
		TX_VALID && $stable(TX_DATA)) else $error("tx byte lost");
	a_note_cause: assert property (VOICE_ON |->
		$past(RX_VALID) && !VOICE_OFF) else $error("bad voice start");
	a_alloff_cause: assert property (ALL_OFF |->
		$past(RX_VALID) && $past(RX_DATA) == 8'h00) else $error("bad all off");
	a_omni_cause: assert property ($changed(OMNI) |->
		$past(RX_VALID) && $past(RX_DATA) == 8'h00) else $error("bad omni");
	a_lower_prog: assert property ($changed(LOWER_PROG) |->
		$past(RX_VALID) && LOWER_PROG <= PROG_MAX) else $error("bad lower");
	a_exc_apply: assert property ($changed({LAYER_MODE, SPLIT_ON,
		SPLIT_KEY, UPPER_PROG}) |-> $past(RX_DATA) == SYS_END)
		else $error("mode set outside F7");
	a_upper_mode: assert property (UPPER_PROG <= PROG_MAX &&
		LAYER_MODE != 2'h3) else $error("bad upper or layer");
	a_tx_status: assert property (TX_VALID && TX_DATA[7] |->
		TX_DATA == ST_NOTE_ON) else $error("foreign status byte sent");
	c_voice: cover property (VOICE_ON);
	c_all_off: cover property (ALL_OFF);
	c_stall: cover property (TX_VALID && !TX_READY);
endmodule
`default_nettype wire

// >>> dv/mni_far_end.sv
// Purpose: far MIDI unit model
// Assumes: byte level traffic
// Notes:   stall holds TX_READY low
`timescale 1ns/100ps
`default_nettype none
module mni_far_end (
	input  wire logic       CLK,      // clock
	input  wire logic       TX_VALID, // byte offered
	input  wire logic [7:0] TX_DATA,  // byte from block
	output logic            TX_READY, // take byte
	output logic            RX_VALID, // byte strobe
	output logic      [7:0] RX_DATA   // byte to block
);
	logic       stall = 1'b0;
	logic [7:0] got[$];
	initial begin
		RX_VALID = 1'b0;
		RX_DATA = 8'h00;
	end
	always @(negedge CLK) TX_READY <= !stall;
	always @(posedge CLK) if (TX_VALID && TX_READY) got.push_back(TX_DATA);
	task send(input logic [7:0] b);
		@(negedge CLK);
		RX_VALID = 1'b1;
		RX_DATA = b;
		@(negedge CLK);
		RX_VALID = 1'b0;
		RX_DATA = ~b; // no stale byte
	endtask
	task sysex(input logic [6:0] id, fn, par);
		send(8'hF0);
		send({1'b0, id});
		send({1'b0, fn});
		send({1'b0, par});
		send(8'hF7);
	endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: self-checking bench for mni_top
// Assumes: far end model drives rx, takes tx
// Notes:   setup window cut to 20 cycles
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top
	import mni_pkg::*;
;
	localparam logic [6:0] OWN_ID    = 7'h11; // arbitrary value
	localparam int         SIM_SETUP = 20;
	logic       CLK, RST, KEY_EVT, KEY_READY, KEY_HELD, MIDI_IN_CONN;
	logic       TX_VALID, TX_READY, RX_VALID, LOCAL_EN, SETUP_DONE;
	logic       VOICE_ON, VOICE_OFF, ALL_OFF, OMNI, SPLIT_ON;
	logic [7:0] TX_DATA, RX_DATA;
	logic [6:0] KEY_IDX, KEY_VEL, KEY_OFFSET, VOICE_KEY, VOICE_VEL, SPLIT_KEY;
	logic [5:0] LOWER_PROG, UPPER_PROG;
	logic [1:0] LAYER_MODE;
	int         err_count = 0, num_checks = 0, on_cnt, off_cnt, all_cnt;
	mni_top #(.SETUP_CNT(SIM_SETUP), .MAKER_ID(OWN_ID)) mni_top_inst (
		.CLK(CLK), .RST(RST), .KEY_EVT(KEY_EVT), .KEY_IDX(KEY_IDX),
		.KEY_VEL(KEY_VEL), .KEY_READY(KEY_READY), .KEY_HELD(KEY_HELD),
		.MIDI_IN_CONN(MIDI_IN_CONN), .TX_VALID(TX_VALID),
		.TX_READY(TX_READY), .TX_DATA(TX_DATA), .RX_VALID(RX_VALID),
		.RX_DATA(RX_DATA), .LOCAL_EN(LOCAL_EN), .SETUP_DONE(SETUP_DONE),
		.KEY_OFFSET(KEY_OFFSET), .VOICE_ON(VOICE_ON), .VOICE_OFF(VOICE_OFF),
		.VOICE_KEY(VOICE_KEY), .VOICE_VEL(VOICE_VEL), .ALL_OFF(ALL_OFF),
		.OMNI(OMNI), .LOWER_PROG(LOWER_PROG), .UPPER_PROG(UPPER_PROG),
		.LAYER_MODE(LAYER_MODE), .SPLIT_ON(SPLIT_ON), .SPLIT_KEY(SPLIT_KEY));
	mni_far_end mni_far_end_inst (.CLK(CLK), .TX_VALID(TX_VALID),
		.TX_DATA(TX_DATA), .TX_READY(TX_READY), .RX_VALID(RX_VALID),
		.RX_DATA(RX_DATA));
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		if (VOICE_ON === 1'b1) on_cnt++;
		if (VOICE_OFF === 1'b1) off_cnt++;
		if (ALL_OFF === 1'b1) all_cnt++;
	end
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task reset_dut(input logic held, input logic [6:0] idx, input bit drop);
		int i;
		@(negedge CLK);
		RST = 1'b1;
		KEY_HELD = held;
		KEY_IDX = idx;
		mni_far_end_inst.got.delete();
		repeat (10) @(negedge CLK);
		RST = 1'b0;
		if (drop) begin
			repeat (5) @(negedge CLK);
			KEY_HELD = 1'b0;
		end
		for (i = 0; i < 200 && SETUP_DONE !== 1'b1; i++) @(negedge CLK);
		`CHK(SETUP_DONE, 1'b1)
		`CHK(i, drop ? SIM_SETUP - 5 : SIM_SETUP)
		KEY_HELD = 1'b0;
	endtask
	task key(input logic [6:0] idx, vel);
		int i;
		for (i = 0; i < 100 && KEY_READY !== 1'b1; i++) @(negedge CLK);
		`CHK(KEY_READY, 1'b1)
		KEY_EVT = 1'b1;
		KEY_IDX = idx;
		KEY_VEL = vel;
		@(negedge CLK);
		KEY_EVT = 1'b0;
	endtask
	task rx(input logic [7:0] a, b, c);
		mni_far_end_inst.send(a);
		mni_far_end_inst.send(b);
		mni_far_end_inst.send(c);
		repeat (3) @(negedge CLK);
	endtask
	task t_keys;
		logic [7:0] exp[6] = '{8'h90, 8'h36, 8'h28, 8'h90, 8'h72, 8'h00};
		int i;
		`CHK(mni_far_end_inst.got.size(), 1)
		`CHK(mni_far_end_inst.got[0], ST_NOTE_ON)
		`CHK(KEY_OFFSET, KEY_BASE)
		MIDI_IN_CONN = 1'b1;
		mni_far_end_inst.stall = 1'b1;
		key(7'h00, 7'h28);
		repeat (6) @(negedge CLK);
		`CHK(LOCAL_EN, 1'b0)
		`CHK({TX_VALID, TX_DATA, KEY_READY}, 10'h320)
		mni_far_end_inst.stall = 1'b0;
		key(7'h3C, 7'h00);
		repeat (20) @(negedge CLK);
		`CHK(mni_far_end_inst.got.size(), 7)
		for (i = 0; i < 6; i++) `CHK(mni_far_end_inst.got[i + 1], exp[i])
		MIDI_IN_CONN = 1'b0;
		@(negedge CLK);
		`CHK(LOCAL_EN, 1'b1)
	endtask
	task t_notes;
		on_cnt = 0;
		off_cnt = 0;
		rx(8'h90, 8'h3C, 8'h40);
		`CHK({on_cnt, VOICE_KEY, VOICE_VEL}, {32'h1, 7'h3C, 7'h40})
		rx(8'h80, 8'h3C, 8'h10);
		rx(8'h90, 8'h3C, 8'h00);
		`CHK(off_cnt, 2)
		mni_far_end_inst.send(8'h3D);
		rx(8'h50, 8'hC0, 8'h3D);
		`CHK({on_cnt, VOICE_KEY, LOWER_PROG}, {32'h2, 7'h3D, 6'h3D})
		rx(8'hC0, 8'h3E, 8'hB0);
		`CHK(LOWER_PROG, 6'h3D)
	endtask
	task t_ctrl;
		on_cnt = 0;
		all_cnt = 0;
		rx(8'h91, 8'h3C, 8'h40);
		`CHK(on_cnt, 1)
		rx(8'hB0, 8'h7C, 8'h00);
		`CHK(OMNI, 1'b0)
		rx(8'h91, 8'h3C, 8'h40);
		rx(8'h90, 8'h3C, 8'h40);
		`CHK(on_cnt, 2)
		rx(8'hB0, 8'h7B, 8'h01);
		rx(8'hB0, 8'h7D, 8'h01);
		`CHK({all_cnt, OMNI}, {32'h0, 1'b0})
		rx(8'hB0, 8'h7B, 8'h00);
		rx(8'hB0, 8'h7E, 8'h00);
		rx(8'hB0, 8'h00, 8'h00);
		`CHK({all_cnt, OMNI}, {32'h1, 1'b0})
		rx(8'hB0, 8'h7D, 8'h00);
		`CHK(OMNI, 1'b1)
	endtask
	task sx(input logic [6:0] id, fn, par, input logic [1:0] lay,
		input logic [6:0] skey, input logic [5:0] up);
		mni_far_end_inst.sysex(id, fn, par);
		repeat (3) @(negedge CLK);
		`CHK(LAYER_MODE, lay)
		`CHK({SPLIT_ON, SPLIT_KEY}, {skey != 7'h00, skey})
		`CHK(UPPER_PROG, up)
	endtask
	task t_trans;
		reset_dut(1'b1, OCTAVE, 1'b0);
		`CHK(KEY_OFFSET, KEY_BASE - OCTAVE)
		key(7'h00, 7'h01);
		repeat (10) @(negedge CLK);
		`CHK(mni_far_end_inst.got[2], {1'b0, KEY_BASE - OCTAVE})
		reset_dut(1'b1, OCTAVE, 1'b1);
		`CHK(KEY_OFFSET, KEY_BASE)
	endtask
	initial begin
		RST = 1'b1;
		KEY_EVT = 1'b0;
		KEY_HELD = 1'b0;
		KEY_IDX = 7'h00;
		KEY_VEL = 7'h00;
		MIDI_IN_CONN = 1'b0;
		reset_dut(1'b0, 7'h00, 1'b0);
		t_keys;
		t_notes;
		t_ctrl;
		sx(OWN_ID, 7'h01, 7'h00, LAYER_UNISON, 7'h00, 6'h00);
		sx(OWN_ID, 7'h00, 7'h00, LAYER_DOUBLE, 7'h00, 6'h00);
		sx(OWN_ID, 7'h01, 7'h05, LAYER_DOUBLE, 7'h00, 6'h00);
		sx(~OWN_ID, 7'h01, 7'h00, LAYER_DOUBLE, 7'h00, 6'h00);
		sx(OWN_ID, 7'h02, 7'h40, LAYER_DOUBLE, 7'h40, 6'h00);
		sx(OWN_ID, 7'h02, 7'h00, LAYER_DOUBLE, 7'h00, 6'h00);
		sx(OWN_ID, 7'h03, 7'h3D, LAYER_DOUBLE, 7'h00, 6'h3D);
		sx(OWN_ID, 7'h03, 7'h3E, LAYER_DOUBLE, 7'h00, 6'h3D);
		t_trans;
		tally_and_finish;
	end
	initial begin
		#50000;
		err_count++;
		tally_and_finish;
	end
endmodule
bind mni_top mni_asserts mni_asserts_inst (.CLK(CLK), .RST(RST),
	.KEY_READY(KEY_READY), .SETUP_DONE(SETUP_DONE), .LOCAL_EN(LOCAL_EN),
	.MIDI_IN_CONN(MIDI_IN_CONN), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
	.TX_DATA(TX_DATA), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
	.VOICE_ON(VOICE_ON), .VOICE_OFF(VOICE_OFF), .ALL_OFF(ALL_OFF),
	.OMNI(OMNI), .LOWER_PROG(LOWER_PROG), .UPPER_PROG(UPPER_PROG),
	.LAYER_MODE(LAYER_MODE), .SPLIT_ON(SPLIT_ON), .SPLIT_KEY(SPLIT_KEY));
`default_nettype wire
